// ---- verilog/cfw_top.sv ----
// Frequency selection and fail-safe watchdog control of the clock synthesizer.
`include "cfw_params.svh"

module cfw_top #(
  parameter int unsigned STEP_SHORT_CYCLES = `CFW_STEP_SHORT_CYCLES,
  parameter int unsigned STEP_LONG_CYCLES = `CFW_STEP_LONG_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Register port
  input wire cfw_pkg::cfw_bus_type bus_in,
  output logic [7:0] rdata_out,
  // Strap pins
  input wire logic [4:0] strap_freq_code_in,
  // Synthesizer side
  output cfw_pkg::cfw_freq_type freq_out,
  output logic freq_load_out,
  output logic sys_reset_out,
  output logic timeout_flag_out
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic prog_en_r;
  logic strap_override_r;
  logic recovery_source_select_r;
  logic [4:0] sw_code_r;
  logic [7:0] cpu_numerator_r;
  logic [6:0] cpu_denominator_r;
  logic [7:0] recovery_numerator_r;
  logic [6:0] recovery_denominator_r;
  logic watchdog_arm_r;
  logic timeout_step_select_r;
  logic reset_on_timeout_r;
  logic reset_on_freq_change_r;
  logic [4:0] timeout_count_r;
  logic timeout_flag_r;
  logic [4:0] strap_code_r;
  logic strap_taken_r;
  logic recovery_active_r;
  logic nm_write_r;
  cfw_pkg::cfw_wd_state_type wd_state_r;
  logic [4:0] remain_r;
  logic [26:0] step_cnt_r;
  logic [4:0] pulse_cnt_r;

  logic wr_en;
  logic flag_clear;
  logic nm_write;
  logic freq_change;
  logic timeout_evt;
  logic step_done;
  logic [26:0] step_last;
  logic [4:0] ratio_code;
  cfw_pkg::cfw_freq_type freq_nxt;

  assign wr_en = bus_in.wr;
  assign flag_clear = wr_en && bus_in.addr == `CFW_ADDR_WD_CTRL &&
                      bus_in.wdata[`CFW_BIT_WD_FLAG];

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_en_r <= 1'b0;
      strap_override_r <= 1'b0;
      recovery_source_select_r <= 1'b0;
      sw_code_r <= `CFW_RST_CODE;
      cpu_numerator_r <= `CFW_RST_BYTE;
      cpu_denominator_r <= `CFW_RST_DEN;
      recovery_numerator_r <= `CFW_RST_BYTE;
      recovery_denominator_r <= `CFW_RST_DEN;
      watchdog_arm_r <= 1'b0;
      timeout_step_select_r <= 1'b0;
      reset_on_timeout_r <= 1'b0;
      reset_on_freq_change_r <= 1'b0;
      timeout_count_r <= `CFW_RST_CODE;
    end else if (wr_en) begin
      case (bus_in.addr)
        `CFW_ADDR_CTRL: begin
          prog_en_r <= bus_in.wdata[`CFW_BIT_PROG_EN];
          strap_override_r <= bus_in.wdata[`CFW_BIT_OVERRIDE];
          recovery_source_select_r <= bus_in.wdata[`CFW_BIT_REC_SRC];
        end
        `CFW_ADDR_SW_SEL: sw_code_r <= bus_in.wdata[4:0];
        `CFW_ADDR_CPU_NUM: cpu_numerator_r <= bus_in.wdata;
        `CFW_ADDR_CPU_DEN: cpu_denominator_r <= bus_in.wdata[6:0];
        `CFW_ADDR_REC_NUM: recovery_numerator_r <= bus_in.wdata;
        `CFW_ADDR_REC_DEN: recovery_denominator_r <= bus_in.wdata[6:0];
        `CFW_ADDR_WD_CTRL: begin
          watchdog_arm_r <= bus_in.wdata[`CFW_BIT_WD_ARM];
          timeout_step_select_r <= bus_in.wdata[`CFW_BIT_WD_STEP];
          reset_on_timeout_r <= bus_in.wdata[`CFW_BIT_RST_TO];
          reset_on_freq_change_r <= bus_in.wdata[`CFW_BIT_RST_FC];
        end
        `CFW_ADDR_WD_COUNT: timeout_count_r <= bus_in.wdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // The straps are caught on the first edge after release, never by the reset itself.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_taken_r <= 1'b0;
      strap_code_r <= `CFW_RST_CODE;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      strap_code_r <= strap_freq_code_in;
    end
  end

  // ****************************************************************
  // Frequency selection
  // ****************************************************************
  assign ratio_code = strap_override_r ? sw_code_r : strap_code_r;

  always_comb begin
    freq_nxt.gear = `CFW_GEAR_E5;
    freq_nxt.code = ratio_code;
    freq_nxt.prog = 1'b0;
    freq_nxt.mult = {1'b0, cpu_numerator_r} + `CFW_OFFSET_NM;
    freq_nxt.div = 8'({1'b0, cpu_denominator_r} + `CFW_OFFSET_NM);
    if (recovery_active_r) begin
      if (recovery_source_select_r) begin
        freq_nxt.prog = 1'b1;
        freq_nxt.mult = {1'b0, recovery_numerator_r} + `CFW_OFFSET_NM;
        freq_nxt.div = 8'({1'b0, recovery_denominator_r} + `CFW_OFFSET_NM);
      end else begin
        freq_nxt.code = strap_code_r;
      end
    end else if (prog_en_r) begin
      freq_nxt.prog = 1'b1;
    end
  end

  // A write to the numerator or denominator in use reloads even when the value is unchanged.
  assign nm_write = wr_en && (((bus_in.addr == `CFW_ADDR_CPU_NUM ||
                    bus_in.addr == `CFW_ADDR_CPU_DEN) && prog_en_r && !recovery_active_r) ||
                    ((bus_in.addr == `CFW_ADDR_REC_NUM || bus_in.addr == `CFW_ADDR_REC_DEN) &&
                    recovery_active_r && recovery_source_select_r));
  assign freq_change = strap_taken_r && ((freq_nxt != freq_out) || nm_write_r);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      freq_out <= '0;
      freq_load_out <= 1'b0;
      nm_write_r <= 1'b0;
    end else begin
      freq_out <= freq_nxt;
      freq_load_out <= freq_change;
      nm_write_r <= nm_write;
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  assign step_last = timeout_step_select_r ? 27'(STEP_LONG_CYCLES - 1) :
                     27'(STEP_SHORT_CYCLES - 1);
  assign step_done = step_cnt_r == step_last;
  assign timeout_evt = wd_state_r == cfw_pkg::CFW_WD_COUNT && watchdog_arm_r &&
                       step_done && remain_r == 5'h00;

  // The recovery switch itself is a frequency change; it must not restart the timer.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wd_state_r <= cfw_pkg::CFW_WD_STOP;
      remain_r <= 5'h00;
      step_cnt_r <= 27'h0000000;
    end else begin
      case (wd_state_r)
        cfw_pkg::CFW_WD_STOP: begin
          remain_r <= timeout_count_r;
          step_cnt_r <= 27'h0000000;
          if (watchdog_arm_r) begin
            wd_state_r <= cfw_pkg::CFW_WD_ARMED;
          end
        end
        cfw_pkg::CFW_WD_ARMED: begin
          remain_r <= timeout_count_r;
          step_cnt_r <= 27'h0000000;
          if (!watchdog_arm_r) begin
            wd_state_r <= cfw_pkg::CFW_WD_STOP;
          end else if (freq_change && !recovery_active_r) begin
            wd_state_r <= cfw_pkg::CFW_WD_COUNT;
          end
        end
        cfw_pkg::CFW_WD_COUNT: begin
          if (!watchdog_arm_r) begin
            wd_state_r <= cfw_pkg::CFW_WD_STOP;
            remain_r <= timeout_count_r;
            step_cnt_r <= 27'h0000000;
          end else if (step_done) begin
            step_cnt_r <= 27'h0000000;
            if (remain_r == 5'h00) begin
              wd_state_r <= cfw_pkg::CFW_WD_ARMED;
            end else begin
              remain_r <= remain_r - 5'h01;
            end
          end else begin
            step_cnt_r <= step_cnt_r + 27'h0000001;
          end
        end
        default: wd_state_r <= cfw_pkg::CFW_WD_STOP;
      endcase
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timeout_flag_r <= 1'b0;
      timeout_flag_out <= 1'b0;
    end else begin
      timeout_flag_r <= timeout_evt | (timeout_flag_r & ~flag_clear);
      timeout_flag_out <= timeout_evt | (timeout_flag_r & ~flag_clear);
    end
  end

  // Recovery holds until software acknowledges the time-out.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      recovery_active_r <= 1'b0;
    end else if (timeout_evt) begin
      recovery_active_r <= 1'b1;
    end else if (flag_clear) begin
      recovery_active_r <= 1'b0;
    end
  end

  // ****************************************************************
  // System reset pulse
  // ****************************************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pulse_cnt_r <= 5'h00;
      sys_reset_out <= 1'b0;
    end else begin
      if ((timeout_evt && reset_on_timeout_r) ||
          (freq_change && reset_on_freq_change_r)) begin
        pulse_cnt_r <= `CFW_RST_PULSE_CYCLES - 5'h01;
        sys_reset_out <= 1'b1;
      end else if (pulse_cnt_r != 5'h00) begin
        pulse_cnt_r <= pulse_cnt_r - 5'h01;
        sys_reset_out <= 1'b1;
      end else begin
        sys_reset_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      case (bus_in.addr)
        `CFW_ADDR_CTRL: rdata_out <= {5'h00, recovery_source_select_r, strap_override_r,
                                      prog_en_r};
        `CFW_ADDR_SW_SEL: rdata_out <= {3'h0, sw_code_r};
        `CFW_ADDR_CPU_NUM: rdata_out <= cpu_numerator_r;
        `CFW_ADDR_CPU_DEN: rdata_out <= {1'b0, cpu_denominator_r};
        `CFW_ADDR_REC_NUM: rdata_out <= recovery_numerator_r;
        `CFW_ADDR_REC_DEN: rdata_out <= {1'b0, recovery_denominator_r};
        `CFW_ADDR_WD_CTRL: rdata_out <= {timeout_flag_r, 3'h0, reset_on_freq_change_r,
                                         reset_on_timeout_r, timeout_step_select_r,
                                         watchdog_arm_r};
        `CFW_ADDR_WD_COUNT: rdata_out <= {3'h0, timeout_count_r};
        `CFW_ADDR_STATUS: rdata_out <= {1'b0, wd_state_r == cfw_pkg::CFW_WD_COUNT,
                                        recovery_active_r, strap_code_r};
        `CFW_ADDR_WD_REMAIN: rdata_out <= {3'h0, remain_r};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_PROG_OFF: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !prog_en_r && !recovery_active_r |=> !freq_out.prog)
    else $error("Programmable source used while disabled.");

  AST_CODE_SRC: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !recovery_active_r && strap_taken_r |=>
    freq_out.code == ($past(strap_override_r) ? $past(sw_code_r) : strap_code_r))
    else $error("Select code from the wrong source.");

  AST_PROG_MULT: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    prog_en_r && !recovery_active_r |=>
    freq_out.mult == {1'b0, $past(cpu_numerator_r)} + 9'h003)
    else $error("Multiplier is not numerator plus three.");

  AST_NM_LOAD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    nm_write && bus_in.addr == `CFW_ADDR_CPU_NUM |-> ##2 freq_load_out)
    else $error("Numerator write did not start a load.");

  AST_ARM_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    !watchdog_arm_r |=> wd_state_r == cfw_pkg::CFW_WD_STOP)
    else $error("Watchdog runs while disarmed.");

  AST_FLAG_SET: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    timeout_evt |=> timeout_flag_r && recovery_active_r)
    else $error("Time-out did not set flag and recovery.");

  AST_FLAG_HOLD: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    timeout_flag_r && !flag_clear |=> timeout_flag_r)
    else $error("Time-out flag dropped without a clear.");

  AST_FLAG_CLEAR: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    timeout_flag_r && flag_clear && !timeout_evt |=> !timeout_flag_r)
    else $error("Write one did not clear the flag.");

  AST_RST_TO: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    timeout_evt && reset_on_timeout_r |=> sys_reset_out [*8])
    else $error("No reset pulse after time-out.");

  AST_RST_QUIET: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(sys_reset_out) |-> $past(freq_change && reset_on_freq_change_r) ||
    $past(timeout_evt && reset_on_timeout_r))
    else $error("Reset pulse without a cause.");

  AST_EXPIRE: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    $rose(recovery_active_r) |-> $past(watchdog_arm_r && remain_r == 5'h00 && step_done))
    else $error("Recovery entered before the count expired.");

  COV_TIMEOUT: cover property (@(posedge clock_in) disable iff (!reset_n_in) timeout_evt);
  COV_REC_PROG: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    recovery_active_r && freq_out.prog);
  COV_FC_RESET: cover property (@(posedge clock_in) disable iff (!reset_n_in)
    freq_change && reset_on_freq_change_r);

endmodule : cfw_top

// ---- pkg/cfw_params.svh ----
// Offsets, field positions, reset values and timing counts of the clock watchdog block.
`ifndef CFW_PARAMS_SVH
`define CFW_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CFW_ADDR_CTRL 4'h0
`define CFW_ADDR_SW_SEL 4'h1
`define CFW_ADDR_CPU_NUM 4'h2
`define CFW_ADDR_CPU_DEN 4'h3
`define CFW_ADDR_REC_NUM 4'h4
`define CFW_ADDR_REC_DEN 4'h5
`define CFW_ADDR_WD_CTRL 4'h6
`define CFW_ADDR_WD_COUNT 4'h7
`define CFW_ADDR_STATUS 4'h8
`define CFW_ADDR_WD_REMAIN 4'h9

// ****************************************************************
// Field positions
// ****************************************************************
`define CFW_BIT_PROG_EN 0
`define CFW_BIT_OVERRIDE 1
`define CFW_BIT_REC_SRC 2
`define CFW_BIT_WD_ARM 0
`define CFW_BIT_WD_STEP 1
`define CFW_BIT_RST_TO 2
`define CFW_BIT_RST_FC 3
`define CFW_BIT_WD_FLAG 7
`define CFW_BIT_REC_ACT 5
`define CFW_BIT_WD_RUN 6

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define CFW_RST_BYTE 8'h00
`define CFW_RST_CODE 5'h00
`define CFW_RST_DEN 7'h00
`define CFW_OFFSET_NM 9'h003
`define CFW_GEAR_E5 23'h4940E5

// ****************************************************************
// Timing
// ****************************************************************
`define CFW_CLK_KHZ 40000
`define CFW_STEP_SHORT_MS 150
`define CFW_STEP_LONG_MS 2500
`define CFW_STEP_SHORT_CYCLES (`CFW_STEP_SHORT_MS * `CFW_CLK_KHZ)
`define CFW_STEP_LONG_CYCLES (`CFW_STEP_LONG_MS * `CFW_CLK_KHZ)
`define CFW_RST_PULSE_CYCLES 5'h10

`endif

// ---- pkg/cfw_pkg.sv ----
// Types shared by the clock watchdog block.
package cfw_pkg;

  // ****************************************************************
  // Frequency setting handed to the synthesizer
  // ****************************************************************
  typedef struct packed {
    logic prog;
    logic [4:0] code;
    logic [8:0] mult;
    logic [7:0] div;
    logic [22:0] gear;
  } cfw_freq_type;

  // ****************************************************************
  // Register port
  // ****************************************************************
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cfw_bus_type;

  // ****************************************************************
  // Watchdog states
  // ****************************************************************
  typedef enum logic [1:0] {
    CFW_WD_STOP = 2'b00,
    CFW_WD_ARMED = 2'b01,
    CFW_WD_COUNT = 2'b10
  } cfw_wd_state_type;

endpackage : cfw_pkg

// ---- verif/cfw_host.sv ----
// Register-port host model that programs the clock watchdog block.
module cfw_host (
  // Clock
  input wire logic clock_in,
  // Register port
  output cfw_pkg::cfw_bus_type bus_out,
  input wire logic [7:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    bus_out = '0;
  end

  // Idle address and data are inverted at the end of every wr and rd task and of every set_nm that writes, so a design that trusts them without a strobe shows up.
  task automatic idle();
    bus_out.wr <= 1'b0;
    bus_out.rd <= 1'b0;
    bus_out.addr <= ~bus_out.addr;
    bus_out.wdata <= ~bus_out.wdata;
  endtask : idle

  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    @(posedge clock_in);
    bus_out <= '{addr, data, 1'b1, 1'b0};
    @(posedge clock_in);
    idle();
  endtask : wr

  task automatic rd(input logic [3:0] addr, output logic [7:0] data);
    @(posedge clock_in);
    bus_out <= '{addr, 8'h00, 1'b0, 1'b1};
    @(posedge clock_in);
    idle();
    @(posedge clock_in);
    data = rdata_in;
  endtask : rd

  // Numerator and denominator go out back to back, and only when the numerator exceeds the denominator, so no half-written ratio lingers.
  task automatic set_nm(input logic [3:0] addr, input logic [7:0] n, input logic [6:0] m);
    if (n > {1'b0, m}) begin
      @(posedge clock_in);
      bus_out <= '{addr, n, 1'b1, 1'b0};
      @(posedge clock_in);
      bus_out <= '{addr + 4'h1, {1'b0, m}, 1'b1, 1'b0};
      @(posedge clock_in);
      idle();
    end
  endtask : set_nm
endmodule : cfw_host

// ---- verif/tb.sv ----
// Self-checking bench for the frequency selection and watchdog block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int unsigned SHORT = 20;
  localparam int unsigned LONG = 50;
  localparam logic [4:0] STRAP = 5'h0A;
  localparam logic [4:0] SOFT = 5'h13;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [4:0] strap_freq_code_in = STRAP;
  cfw_pkg::cfw_bus_type bus_in;
  logic [7:0] rdata_out;
  cfw_pkg::cfw_freq_type freq_out;
  logic freq_load_out;
  logic sys_reset_out;
  logic timeout_flag_out;
  int failures = 0;
  int checks = 0;
  int rst_cycles = 0;
  int base;
  int n;
  logic [7:0] rv;

  always #12.5 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    if (sys_reset_out === 1'b1) begin
      rst_cycles <= rst_cycles + 1;
    end
  end

  cfw_top #(.STEP_SHORT_CYCLES(SHORT), .STEP_LONG_CYCLES(LONG)) cfw_top_inst (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .bus_in(bus_in),
    .rdata_out(rdata_out),
    .strap_freq_code_in(strap_freq_code_in),
    .freq_out(freq_out),
    .freq_load_out(freq_load_out),
    .sys_reset_out(sys_reset_out),
    .timeout_flag_out(timeout_flag_out)
  );

  cfw_host cfw_host_inst (
    .clock_in(clock_in),
    .bus_out(bus_in),
    .rdata_in(rdata_out)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clock_in);
    #1;
  endtask : tick

  // The wait is bounded, so a watchdog that never fires is reported rather than hung on.
  task automatic wait_flag(output int cyc);
    cyc = 0;
    while (timeout_flag_out !== 1'b1 && cyc < 400) begin
      tick(1);
      cyc++;
    end
  endtask : wait_flag

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    tick(3);
    for (int a = 0; a < 10; a++) begin
      cfw_host_inst.rd(4'(a), rv);
      check(32'(rv), (a == 8) ? 32'(STRAP) : 32'h0);
    end
    cfw_host_inst.rd(4'hF, rv);
    check(32'(rv), 32'h0);
    check(32'(freq_out.prog), 32'h0);
    check(32'(freq_out.code), 32'(STRAP));
    // The straps are latched once, so a later pin change must not reach the output.
    @(posedge clock_in);
    strap_freq_code_in <= 5'h15;
    tick(2);
    check(32'(freq_out.code), 32'(STRAP));
    check(32'(freq_out.gear), 32'h4940E5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_override();
    cfw_host_inst.wr(4'h1, 8'(SOFT));
    cfw_host_inst.wr(4'h0, 8'h02);
    tick(2);
    check(32'(freq_out.code), 32'(SOFT));
    check(32'(freq_out.prog), 32'h0);
    cfw_host_inst.wr(4'h0, 8'h00);
    tick(2);
    check(32'(freq_out.code), 32'(STRAP));
    $display("test override done");
  endtask : t_override

  task automatic t_prog();
    cfw_host_inst.set_nm(4'h2, 8'hA0, 7'h5D);
    cfw_host_inst.wr(4'h0, 8'h01);
    tick(2);
    check(32'(freq_out.prog), 32'h1);
    check(32'(freq_out.mult), 32'h0A3);
    check(32'(freq_out.div), 32'h60);
    check(32'(freq_out.code), 32'(STRAP));
    check(32'(freq_out.gear), 32'h4940E5);
    cfw_host_inst.wr(4'h0, 8'h03);
    tick(2);
    check(32'(freq_out.code), 32'(SOFT));
    cfw_host_inst.wr(4'h2, 8'hA8);
    tick(1);
    check(32'(freq_load_out), 32'h1);
    check(32'(freq_out.mult), 32'h0AB);
    cfw_host_inst.wr(4'h3, 8'h50);
    tick(1);
    check(32'(freq_load_out), 32'h1);
    check(32'(freq_out.div), 32'h53);
    $display("test programmed done");
  endtask : t_prog

  task automatic t_recover_nm();
    cfw_host_inst.set_nm(4'h4, 8'h80, 7'h2D);
    cfw_host_inst.wr(4'h7, 8'h01);
    cfw_host_inst.wr(4'h0, 8'h07);
    cfw_host_inst.wr(4'h6, 8'h05);
    tick(3);
    base = rst_cycles;
    cfw_host_inst.wr(4'h2, 8'hB0);
    wait_flag(n);
    check(32'(n >= 2 * SHORT && n <= 2 * SHORT + 4), 32'h1);
    tick(2);
    check(32'(freq_out.prog), 32'h1);
    check(32'(freq_out.mult), 32'h083);
    check(32'(freq_out.div), 32'h30);
    check(32'(freq_out.code), 32'(SOFT));
    cfw_host_inst.rd(4'h6, rv);
    check(32'(rv[7]), 32'h1);
    cfw_host_inst.wr(4'h4, 8'h90);
    tick(1);
    check(32'(freq_load_out), 32'h1);
    check(32'(freq_out.mult), 32'h093);
    tick(30);
    check(32'(rst_cycles - base), 32'h10);
    cfw_host_inst.wr(4'h6, 8'h05);
    tick(2);
    check(32'(timeout_flag_out), 32'h1);
    cfw_host_inst.wr(4'h6, 8'h80);
    tick(2);
    check(32'(timeout_flag_out), 32'h0);
    tick(5 * SHORT);
    check(32'(timeout_flag_out), 32'h0);
    $display("test recovery from values done");
  endtask : t_recover_nm

  task automatic t_recover_strap();
    cfw_host_inst.wr(4'h7, 8'h00);
    cfw_host_inst.wr(4'h0, 8'h01);
    cfw_host_inst.wr(4'h6, 8'h03);
    tick(3);
    base = rst_cycles;
    cfw_host_inst.wr(4'h2, 8'hB8);
    wait_flag(n);
    check(32'(n >= LONG && n <= LONG + 4), 32'h1);
    tick(2);
    check(32'(freq_out.prog), 32'h0);
    check(32'(freq_out.code), 32'(STRAP));
    tick(20);
    check(32'(rst_cycles - base), 32'h0);
    cfw_host_inst.wr(4'h6, 8'h80);
    tick(2);
    $display("test recovery from straps done");
  endtask : t_recover_strap

  task automatic t_disarm();
    cfw_host_inst.wr(4'h7, 8'h01);
    cfw_host_inst.wr(4'h6, 8'h01);
    tick(3);
    cfw_host_inst.wr(4'h2, 8'hC0);
    tick(SHORT);
    cfw_host_inst.rd(4'h8, rv);
    check(32'(rv[6]), 32'h1);
    cfw_host_inst.wr(4'h6, 8'h00);
    cfw_host_inst.rd(4'h9, rv);
    check(32'(rv), 32'h1);
    tick(4 * SHORT);
    check(32'(timeout_flag_out), 32'h0);
    cfw_host_inst.wr(4'h6, 8'h01);
    tick(4 * SHORT);
    check(32'(timeout_flag_out), 32'h0);
    cfw_host_inst.wr(4'h6, 8'h00);
    $display("test disarm done");
  endtask : t_disarm

  task automatic t_freq_change_reset();
    cfw_host_inst.wr(4'h6, 8'h08);
    base = rst_cycles;
    cfw_host_inst.wr(4'h2, 8'hC8);
    tick(30);
    check(32'(rst_cycles - base), 32'h10);
    cfw_host_inst.wr(4'h6, 8'h00);
    tick(2);
    base = rst_cycles;
    cfw_host_inst.wr(4'h2, 8'hD0);
    tick(30);
    check(32'(rst_cycles - base), 32'h0);
    $display("test change reset done");
  endtask : t_freq_change_reset

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_override();
    t_prog();
    t_recover_nm();
    t_recover_strap();
    t_disarm();
    t_freq_change_reset();
    results();
  end

  // The run needs about six hundred and fifty cycles; this span leaves ample margin.
  initial begin
    #500us;
    failures++;
    results();
  end
endmodule : tb
